/* dv/cnv_properties.sv */
// timing checks on the link between the cpu end and the store end
// assumes one clock, reset active low, instantiated beside the interface
`timescale 1ns/1ns
`default_nettype none
module cnv_properties import cnv_pkg::*; #(
  parameter int PROG_CNT = PROG_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic fetch_req,
  input wire logic store_req,
  input wire logic ctl_wr,
  input wire logic unlock_wr,
  input wire logic flag_clr,
  input wire logic [AW-1:0] table_pointer,
  input wire logic [DW-1:0] wdata,
  input wire logic [DW-1:0] table_latch,
  input wire logic [DW-1:0] store_control,
  input wire logic stall,
  input wire logic store_done_flag
);
  localparam int PDLY = PROG_CNT;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // requests are only taken while nothing is in flight
  wire dev_idle = !stall && !store_control[CTL_GO];
  wire go = store_control[CTL_GO];

  AST_FETCH_STALL: assert property (fetch_req && dev_idle |=> stall ##1 !stall)
    else $error("fetch did not stall for one cycle");
  AST_FETCH_ZERO: assert property (fetch_req && dev_idle && table_pointer > 8'h3F
    |=> ##1 table_latch == BYTE_ZERO)
    else $error("unmapped fetch did not return zero");
  AST_LATCH_LOAD: assert property (store_req && dev_idle |=> table_latch == $past(wdata))
    else $error("table store did not load latch");
  AST_GO_ARM: assert property ($rose(go) |-> $past(store_control[CTL_ARM]))
    else $error("go rose without arm");
  AST_ARM_SW: assert property (!$stable(store_control[CTL_ARM]) |-> $past(ctl_wr))
    else $error("arm changed without a control write");
  AST_PROG_LEN: assert property ($rose(go) |-> stall ##PDLY (stall && go)
    ##1 (!stall && !go && store_done_flag))
    else $error("program cycle length or completion wrong");
  AST_GO_STALL: assert property (go |-> stall)
    else $error("go high without stall");
  AST_FAULT_QUIET: assert property ($rose(store_control[CTL_FAULT]) |-> !stall && !go)
    else $error("fault rose with an operation running");
  AST_SPACE_GO: assert property ($rose(go) |-> store_control[CTL_SPC_LO])
    else $error("go accepted with bad space select");
  AST_DONE_CLR: assert property ($fell(store_done_flag) |-> $past(flag_clr))
    else $error("done flag fell without clear");
endmodule
`default_nettype wire

/* dv/config_userid_nvm_access_bench.sv */
// bench joining the cpu end and the store end through the link
// assumes the software port answers reads one cycle later and never waits
`timescale 1ns/1ns
`default_nettype none
module config_userid_nvm_access_bench import cnv_pkg::*;;
  localparam int PCNT = 4;
  logic ref_clk, rst_n, por_n, prot_n, wr, rd;
  logic [2:0] addr;
  logic [7:0] wdat, rdata, cfg_act;
  int bad_count, cmp_count;

  cnv_if cnv_if_i ();
  cnv_dev #(.PROG_CNT(PCNT)) cnv_dev_i (.REF_CLK(ref_clk), .RST_N(rst_n), .POR_N(por_n),
    .CFG_PROTECT_N(prot_n), .BUS(cnv_if_i.dev), .CFG_ACTIVE(cfg_act));
  cnv_cpu cnv_cpu_i (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdat), .WR(wr),
    .RD(rd), .RDATA(rdata), .BUS(cnv_if_i.cpu));
  cnv_properties #(.PROG_CNT(PCNT)) cnv_properties_i (.REF_CLK(ref_clk), .RST_N(rst_n),
    .fetch_req(cnv_if_i.fetch_req), .store_req(cnv_if_i.store_req),
    .ctl_wr(cnv_if_i.ctl_wr), .unlock_wr(cnv_if_i.unlock_wr), .flag_clr(cnv_if_i.flag_clr),
    .table_pointer(cnv_if_i.table_pointer), .wdata(cnv_if_i.wdata),
    .table_latch(cnv_if_i.table_latch), .store_control(cnv_if_i.store_control),
    .stall(cnv_if_i.stall), .store_done_flag(cnv_if_i.store_done_flag));

  // 20 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes on the software port
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // poll busy with a bound; a hang ends the run
  task automatic wait_idle();
    logic [7:0] s;
    for (int i = 0; i < 100; i++) begin
      rd_reg(HR_STAT, s);
      if (s[2:1] === 2'b00) return; // walk idle and store no longer stalled
    end
    bad_count++;
    end_of_test();
  endtask

  task automatic cmd(input logic [7:0] p, input logic [7:0] d, input logic [7:0] c);
    wr_reg(HR_PTR, p);
    wr_reg(HR_DATA, d);
    wr_reg(HR_CMD, c);
    wait_idle();
  endtask

  task automatic fetch(input logic [7:0] p, output logic [7:0] d);
    wr_reg(HR_PTR, p);
    wr_reg(HR_FETCH, 8'h00);
    wait_idle();
    rd_reg(HR_DATA, d);
  endtask

  // reset held 8 cycles; two edges pass before the next request
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic s_config();
    logic [7:0] v;
    wr_reg(HR_SPACE, 8'h40);
    cmd(8'h10, 8'h5A, 8'h00);
    chk("cfg_active", cfg_act, 8'h5A);
    rd_reg(HR_STAT, v);
    chk("done_set", v & 8'h01, 8'h01);
    wr_reg(HR_STAT, 8'h01);
    rd_reg(HR_STAT, v);
    chk("done_clr", v & 8'h01, 8'h00);
    fetch(8'h10, v);
    chk("cfg_fetch", v, 8'h5A);
    wr_reg(HR_SPACE, 8'hC0);
    cmd(8'h11, 8'hA5, 8'h01);
    fetch(8'h11, v);
    chk("cfg_space11", v, 8'hA5);
  endtask

  // erase, program, program over a programmed byte, then the automatic walk
  task automatic s_uid();
    logic [7:0] v;
    cmd(8'h03, 8'hC3, 8'h01);
    fetch(8'h03, v);
    chk("uid_erase", v, ERASED_BYTE);
    cmd(8'h03, 8'hC3, 8'h00);
    fetch(8'h03, v);
    chk("uid_prog", v, 8'hC3);
    cmd(8'h03, 8'h0F, 8'h00);
    fetch(8'h03, v);
    chk("uid_no_erase", v, 8'h03);
    cmd(8'h04, 8'h96, 8'h02);
    fetch(8'h04, v);
    chk("uid_auto", v, 8'h96);
  endtask

  // protected word, read-only area, unmapped target, bad space select
  task automatic s_refuse();
    logic [7:0] v;
    logic [7:0] tp [4] = '{8'h10, 8'h20, 8'h45, 8'h10};
    logic [7:0] ts [4] = '{8'h40, 8'h40, 8'h40, 8'h00};
    for (int i = 0; i < 4; i++) begin
      prot_n <= (i != 0);
      wr_reg(HR_SPACE, ts[i]);
      cmd(tp[i], 8'h11, (i == 2) ? 8'h02 : 8'h00);
      rd_reg(HR_SPACE, v);
      chk("fault", v & 8'h08, 8'h08);
      chk("cfg_kept", cfg_act, 8'h5A);
      wr_reg(HR_SPACE, 8'h40);
    end
    rd_reg(HR_SPACE, v);
    chk("fault_clr", v & 8'h08, 8'h00);
    fetch(8'h50, v);
    chk("unmapped_fetch", v, BYTE_ZERO);
    // a command without fresh data is refused and flagged
    wr_reg(HR_CMD, 8'h00);
    rd_reg(HR_STAT, v);
    chk("cmd_unloaded", v & 8'h08, 8'h08);
    wr_reg(HR_STAT, 8'h02);
    rd_reg(HR_STAT, v);
    chk("err_clr", v & 8'h08, 8'h00);
  endtask

  // reset in mid-program, then a reset with nothing running
  task automatic s_reset();
    logic [7:0] v;
    wr_reg(HR_PTR, 8'h05);
    wr_reg(HR_DATA, 8'h33);
    wr_reg(HR_CMD, 8'h02);
    repeat (7) @(posedge ref_clk);
    do_reset();
    rd_reg(HR_SPACE, v);
    chk("fault_reset", v & 8'h08, 8'h08);
    chk("cfg_reload", cfg_act, 8'h5A);
    wr_reg(HR_SPACE, 8'h40);
    rd_reg(HR_SPACE, v);
    chk("fault_cleared", v & 8'h08, 8'h00);
    do_reset();
    rd_reg(HR_SPACE, v);
    chk("fault_again", v & 8'h08, 8'h08);
  endtask

  // bound on the whole run
  initial begin
    repeat (50000) @(posedge ref_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    prot_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdat = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge ref_clk);
    por_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    s_config();
    s_uid();
    s_refuse();
    s_reset();
    end_of_test();
  end
endmodule
`default_nettype wire

/* rtl/cnv_cpu.sv */
// cpu end: software registers turned into table and control requests
// assumes software uses the plain port; write commands run the full arm/unlock/go/disarm walk
`timescale 1ns/1ns
`default_nettype none
module cnv_cpu import cnv_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic [2:0] ADDR,
  input wire logic [DW-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DW-1:0] RDATA,
  cnv_if.cpu BUS
);
  cnv_hst_e hs_reg, hs_next;
  logic [AW-1:0] ptr_reg;
  logic [1:0] spc_reg;
  logic ptr_ld_reg, dat_ld_reg, err_reg, ers_reg, auto_reg;
  logic fetch_reg, store_reg, ctl_reg, unl_reg, clr_reg;
  logic [DW-1:0] bwd_reg, bwd_next, rdata_reg;
  logic ers_next, auto_next;

  // software request decode
  wire sw_ok = (hs_reg == HS_IDLE) && !BUS.stall;
  wire wr_ptr = WR && ADDR == HR_PTR;
  wire wr_dat = WR && ADDR == HR_DATA;
  wire wr_spc = WR && ADDR == HR_SPACE;
  wire wr_fet = WR && ADDR == HR_FETCH;
  wire wr_cmd = WR && ADDR == HR_CMD;
  wire wr_sta = WR && ADDR == HR_STAT;
  wire loaded = ptr_ld_reg && dat_ld_reg;
  wire cmd_go = wr_cmd && sw_ok && loaded;
  wire busy_op = wr_ptr || wr_dat || wr_spc || wr_fet || wr_cmd;
  wire refuse = (busy_op && !sw_ok) || (wr_cmd && !loaded);
  wire dev_free = !BUS.stall && !BUS.store_control[CTL_GO];
  wire dev_fault = BUS.store_control[CTL_FAULT];
  wire [DW-1:0] stat = {4'h0, err_reg, (hs_reg != HS_IDLE), BUS.stall, BUS.store_done_flag};
  wire [DW-1:0] rd_next = (ADDR == HR_PTR) ? ptr_reg :
                          (ADDR == HR_DATA) ? BUS.table_latch :
                          (ADDR == HR_SPACE) ? BUS.store_control :
                          (ADDR == HR_STAT) ? stat : BYTE_ZERO;

  // write-command walk: arm, two keys, go, wait, disarm
  always_comb begin
    hs_next = hs_reg;
    ers_next = ers_reg;
    auto_next = auto_reg;
    bwd_next = WDATA;
    unique case (hs_reg)
      HS_IDLE: begin
        if (cmd_go) begin
          hs_next = HS_ARM;
          auto_next = WDATA[1] && is_uid(ptr_reg);
          ers_next = WDATA[0] || (WDATA[1] && is_uid(ptr_reg));
        end
      end
      HS_ARM: begin
        hs_next = HS_KEY1;
        bwd_next = UNLOCK_KEY1;
      end
      HS_KEY1: begin
        hs_next = HS_KEY2;
        bwd_next = UNLOCK_KEY2;
      end
      HS_KEY2: begin
        hs_next = HS_GO;
        bwd_next = ctl_byte(spc_reg, ers_reg, 1'b1, 1'b1);
      end
      HS_GO: hs_next = HS_WAIT;
      HS_WAIT: begin
        if (dev_free) begin
          if (auto_reg && ers_reg && !dev_fault) begin
            hs_next = HS_ARM; // erase done, now program the byte
            ers_next = 1'b0;
          end else begin
            hs_next = HS_DISARM;
            bwd_next = ctl_byte(spc_reg, 1'b0, 1'b0, 1'b0);
          end
        end
      end
      HS_DISARM: hs_next = HS_IDLE;
      default: hs_next = HS_IDLE;
    endcase
    if (hs_reg == HS_IDLE && cmd_go) begin
      bwd_next = ctl_byte(spc_reg, 1'b0, 1'b1, 1'b0);
    end else if (hs_reg == HS_IDLE && wr_spc) begin
      bwd_next = {WDATA[CTL_SPC_LO +: 2], 2'h0, WDATA[CTL_FAULT], 3'h0};
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hs_reg <= HS_IDLE;
      {ers_reg, auto_reg} <= 2'h0;
      bwd_reg <= '0;
      rdata_reg <= '0;
    end else begin
      hs_reg <= hs_next;
      {ers_reg, auto_reg} <= {ers_next, auto_next};
      bwd_reg <= bwd_next;
      rdata_reg <= RD ? rd_next : rdata_reg;
    end
  end

  // one-cycle request pulses toward the store
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {fetch_reg, store_reg, ctl_reg, unl_reg, clr_reg} <= '0;
    end else begin
      fetch_reg <= wr_fet && sw_ok;
      store_reg <= wr_dat && sw_ok;
      ctl_reg <= (wr_spc && sw_ok) || cmd_go || hs_next == HS_GO || hs_next == HS_DISARM;
      unl_reg <= (hs_next == HS_KEY1) || (hs_next == HS_KEY2);
      clr_reg <= wr_sta && WDATA[0];
    end
  end

  // pointer, space and load tracking; a finished command needs fresh data
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_reg <= '0;
      spc_reg <= SPACE_RESET;
      {ptr_ld_reg, dat_ld_reg, err_reg} <= 3'h0;
    end else begin
      ptr_reg <= (wr_ptr && sw_ok) ? WDATA : ptr_reg;
      spc_reg <= (wr_spc && sw_ok) ? WDATA[CTL_SPC_LO +: 2] : spc_reg;
      ptr_ld_reg <= (wr_ptr && sw_ok) || (ptr_ld_reg && hs_reg != HS_DISARM);
      dat_ld_reg <= (wr_dat && sw_ok) || (dat_ld_reg && hs_reg != HS_DISARM);
      err_reg <= refuse || (err_reg && !(wr_sta && WDATA[1]));
    end
  end

  assign BUS.fetch_req = fetch_reg;
  assign BUS.store_req = store_reg;
  assign BUS.ctl_wr = ctl_reg;
  assign BUS.unlock_wr = unl_reg;
  assign BUS.flag_clr = clr_reg;
  assign BUS.table_pointer = ptr_reg;
  assign BUS.wdata = bwd_reg;
  assign RDATA = rdata_reg;
endmodule
`default_nettype wire

/* rtl/cnv_dev.sv */
// configuration-space store end: table fetch/store, control byte, unlock, program cycle
// assumes the cpu end holds off new requests while stall is high
// Function
// - access only with space select 01 or 11
// - fetch copies addressed byte to latch, stalls
// - fetch outside map returns all zeros
// - only user ids and config words writable
// - go blocked unless arm already set
// - arm changes only by software write
// - software keeps arm clear outside updates
// - load pointer and latch before command
// - unlock before any config word write
// - protected or invalid target: fault, no write
// - config write: one byte, own erase
// - config write stalls, clears go, sets done
// - new config value active after resume
// - user id needs erase command first
// - unlock needed for user id erase, program
// - user id erase sets byte to FF
// - user id program: store, command, done
// - new user id active after resume
// - invalid user id target: fault, no effect
// - reset during program cycle sets fault
// - after cleared reset fault, every reset sets it
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module cnv_dev import cnv_pkg::*; #(
  parameter int PROG_CNT = PROG_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic POR_N,
  input wire logic CFG_PROTECT_N,
  cnv_if.dev BUS,
  output logic [DW-1:0] CFG_ACTIVE
);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(PROG_CNT - 1);

  cnv_dst_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DW-1:0] latch_reg, latch_next;
  logic [1:0] space_reg, space_next;
  logic erase_reg, arm_reg, go_reg, fault_reg, done_reg, stall_reg;
  logic erase_next, arm_next, go_next, fault_next, done_next;
  logic [1:0] unl_reg, unl_next;
  logic prot_meta_reg, prot_sync_reg;
  logic rst_seen_reg, fault_rst_reg, fault_rst_next;
  logic post_rst_reg;
  logic [AW-1:0] tgt_reg, tgt_next;
  logic [DW-1:0] pdata_reg, pdata_next;
  logic [DW-1:0] cfg_act_reg, cfg_act_next;

  wire idle = (state_reg == DS_IDLE);
  wire [AW-1:0] tp = BUS.table_pointer;
  wire [DW-1:0] wd = BUS.wdata;
  wire [AW-1:0] rd_addr = !rst_seen_reg ? CFGW_BASE : (idle ? tp : tgt_reg);
  wire [DW-1:0] rd_data;
  wire hv_ret, quirk_ret;

  // decode of the request in the current cycle
  wire space_ok = (space_reg == SPACE_CFG_A) || (space_reg == SPACE_CFG_B);
  wire fetch_go = BUS.fetch_req && idle;
  wire store_go = BUS.store_req && idle;
  wire ctl_go = BUS.ctl_wr && idle;
  wire [DW-1:0] fetch_byte = (space_ok && is_mapped(tgt_reg)) ? rd_data : BYTE_ZERO;
  // go needs arm from before this write and a fresh unlock
  wire go_req = ctl_go && wd[CTL_GO] && arm_reg && (unl_reg == UNL_OPEN);
  wire tgt_ok = space_ok && (is_uid(tp) || is_cfgw(tp));
  wire cfg_locked = is_cfgw(tp) && !prot_sync_reg;
  wire go_bad = go_req && (!tgt_ok || cfg_locked);
  wire go_ok = go_req && !go_bad;
  wire ers_sel = wd[CTL_ERASE];
  // config words erase implicitly; user ids only clear bits unless erased
  wire [DW-1:0] new_byte = is_cfgw(tp) ? latch_reg :
                           (ers_sel ? ERASED_BYTE : (rd_data & latch_reg));
  wire fault_clr = ctl_go && !wd[CTL_FAULT];
  wire rst_fault = !rst_seen_reg && (hv_ret || quirk_ret);
  wire done_pulse = (state_reg == DS_DONE);

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    tgt_next = tgt_reg;
    pdata_next = pdata_reg;
    unique case (state_reg)
      DS_IDLE: begin
        if (fetch_go) begin
          state_next = DS_FETCH;
          tgt_next = tp;
        end else if (go_ok) begin
          state_next = DS_PROG;
          cnt_next = CNT_LOAD;
          tgt_next = tp;
          pdata_next = new_byte;
        end
      end
      DS_FETCH: state_next = DS_IDLE;
      DS_PROG: begin
        if (cnt_reg == '0) begin
          state_next = DS_DONE;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      DS_DONE: state_next = DS_IDLE;
      default: state_next = DS_IDLE;
    endcase
  end

  // control byte, latch and flags
  always_comb begin
    latch_next = latch_reg;
    if (state_reg == DS_FETCH) begin
      latch_next = fetch_byte;
    end else if (store_go) begin
      latch_next = wd;
    end
    space_next = ctl_go ? wd[CTL_SPC_LO +: 2] : space_reg;
    erase_next = ctl_go ? ers_sel : erase_reg;
    arm_next = ctl_go ? wd[CTL_ARM] : arm_reg;
    go_next = go_ok | (go_reg & ~done_pulse);
    // set beats clear when both land together
    fault_next = go_bad | rst_fault | (fault_reg & ~fault_clr);
    fault_rst_next = rst_fault | (fault_rst_reg & ~fault_clr);
    done_next = done_pulse | (done_reg & ~BUS.flag_clr);
    cfg_act_next = cfg_act_reg;
    if (!rst_seen_reg || (done_pulse && tgt_reg == CFGW_BASE)) begin
      cfg_act_next = !rst_seen_reg ? rd_data : pdata_reg;
    end
  end

  // unlock tracker: any other table or control access breaks the sequence
  always_comb begin
    unl_next = unl_reg;
    if (BUS.unlock_wr && idle) begin
      if (wd == UNLOCK_KEY1) begin
        unl_next = UNL_HALF;
      end else if (unl_reg == UNL_HALF && wd == UNLOCK_KEY2) begin
        unl_next = UNL_OPEN;
      end else begin
        unl_next = UNL_NONE;
      end
    end else if (fetch_go || store_go || ctl_go) begin
      unl_next = UNL_NONE;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= DS_IDLE;
      cnt_reg <= '0;
      tgt_reg <= '0;
      pdata_reg <= '0;
      latch_reg <= '0;
      space_reg <= SPACE_RESET;
      unl_reg <= UNL_NONE;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      tgt_reg <= tgt_next;
      pdata_reg <= pdata_next;
      latch_reg <= latch_next;
      space_reg <= space_next;
      unl_reg <= unl_next;
    end
  end

  // flags; stall follows the sequencer so the cpu is held from the request on
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {erase_reg, arm_reg, go_reg, fault_reg, done_reg, stall_reg} <= '0;
      fault_rst_reg <= 1'b0;
      rst_seen_reg <= 1'b0;
      post_rst_reg <= 1'b0;
      cfg_act_reg <= '0;
    end else begin
      {erase_reg, arm_reg, go_reg, fault_reg} <= {erase_next, arm_next, go_next, fault_next};
      done_reg <= done_next;
      stall_reg <= (state_next != DS_IDLE);
      fault_rst_reg <= fault_rst_next;
      rst_seen_reg <= 1'b1;
      post_rst_reg <= rst_seen_reg; // high from the second cycle after reset on
      cfg_act_reg <= cfg_act_next;
    end
  end

  // protect pin comes from outside; reset to protected is the safe side
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prot_meta_reg <= 1'b0;
      prot_sync_reg <= 1'b0;
    end else begin
      prot_meta_reg <= CFG_PROTECT_N;
      prot_sync_reg <= prot_meta_reg;
    end
  end

  // the array and the bits that outlive a system reset
  cnv_store #(.DEPTH(MEM_DEPTH)) u_store (
    .clk(REF_CLK),
    .por_n(POR_N),
    .rd_idx(rd_addr[IDX_W-1:0]),
    .rd_data(rd_data),
    .we(done_pulse),
    .wr_idx(tgt_reg[IDX_W-1:0]),
    .wr_data(pdata_reg),
    .hv_set(idle && go_ok),
    // clear only once the fault has been captured; clearing while reset is held hides it
    .hv_clr(done_pulse || (rst_seen_reg && !post_rst_reg)),
    .quirk_set(fault_clr && fault_rst_reg),
    .hv_ret(hv_ret),
    .quirk_ret(quirk_ret)
  );

  assign BUS.table_latch = latch_reg;
  assign BUS.store_control = {space_reg, 2'h0, fault_reg, erase_reg, arm_reg, go_reg};
  assign BUS.stall = stall_reg;
  assign BUS.store_done_flag = done_reg;
  assign CFG_ACTIVE = cfg_act_reg;
endmodule
`default_nettype wire

/* rtl/cnv_dev_placeholder_removed.sv */
`timescale 1ns/1ns

/* rtl/cnv_if.sv */
// link between the cpu end and the configuration-space store end
// assumes both ends run on the same clock; every signal is driven from a flop
`timescale 1ns/1ns
`default_nettype none
interface cnv_if;
  import cnv_pkg::*;
  logic fetch_req;
  logic store_req;
  logic ctl_wr;
  logic unlock_wr;
  logic flag_clr;
  logic [AW-1:0] table_pointer;
  logic [DW-1:0] wdata;
  logic [DW-1:0] table_latch;
  logic [DW-1:0] store_control;
  logic stall;
  logic store_done_flag;

  modport cpu (
    output fetch_req, store_req, ctl_wr, unlock_wr, flag_clr, table_pointer, wdata,
    input table_latch, store_control, stall, store_done_flag
  );
  modport dev (
    input fetch_req, store_req, ctl_wr, unlock_wr, flag_clr, table_pointer, wdata,
    output table_latch, store_control, stall, store_done_flag
  );
endinterface
`default_nettype wire

/* rtl/cnv_pkg.sv */
// constants, address map, field layout and state codes for the configuration-space store
// assumes one 20 MHz system clock shared by both ends
package cnv_pkg;
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int IDX_W = 6;
  localparam int MEM_DEPTH = 64;
  localparam int CNT_W = 16;

  // configuration-space map, byte addresses
  localparam logic [AW-1:0] UID_BASE = 8'h00;
  localparam logic [AW-1:0] UID_LAST = 8'h07;
  localparam logic [AW-1:0] CFGW_BASE = 8'h10;
  localparam logic [AW-1:0] CFGW_LAST = 8'h19;
  localparam logic [AW-1:0] INFO_BASE = 8'h20;
  localparam logic [AW-1:0] INFO_LAST = 8'h2F;
  localparam logic [AW-1:0] DCFG_BASE = 8'h30;
  localparam logic [AW-1:0] DCFG_LAST = 8'h37;
  localparam logic [AW-1:0] ID_BASE = 8'h3C;
  localparam logic [AW-1:0] ID_LAST = 8'h3F;

  // store_control field positions and values
  localparam int CTL_GO = 0;
  localparam int CTL_ARM = 1;
  localparam int CTL_ERASE = 2;
  localparam int CTL_FAULT = 3;
  localparam int CTL_SPC_LO = 6;
  localparam logic [1:0] SPACE_CFG_A = 2'h1;
  localparam logic [1:0] SPACE_CFG_B = 2'h3;
  localparam logic [1:0] SPACE_RESET = 2'h0;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] ERASED_BYTE = 8'hFF;

  // unlock keys, values arbitrary
  localparam logic [DW-1:0] UNLOCK_KEY1 = 8'hA3;
  localparam logic [DW-1:0] UNLOCK_KEY2 = 8'h3A;
  localparam logic [1:0] UNL_NONE = 2'h0;
  localparam logic [1:0] UNL_HALF = 2'h1;
  localparam logic [1:0] UNL_OPEN = 2'h2;

  // high-voltage cycle time, least time so rounded up
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // controller register offsets on the software port
  localparam logic [2:0] HR_PTR = 3'h0;
  localparam logic [2:0] HR_DATA = 3'h1;
  localparam logic [2:0] HR_SPACE = 3'h2;
  localparam logic [2:0] HR_FETCH = 3'h3;
  localparam logic [2:0] HR_CMD = 3'h4;
  localparam logic [2:0] HR_STAT = 3'h5;

  typedef enum logic [3:0] {
    DS_IDLE = 4'h1,
    DS_FETCH = 4'h2,
    DS_PROG = 4'h4,
    DS_DONE = 4'h8
  } cnv_dst_e;

  typedef enum logic [6:0] {
    HS_IDLE = 7'h01,
    HS_ARM = 7'h02,
    HS_KEY1 = 7'h04,
    HS_KEY2 = 7'h08,
    HS_GO = 7'h10,
    HS_WAIT = 7'h20,
    HS_DISARM = 7'h40
  } cnv_hst_e;

  function automatic logic in_rng(input logic [AW-1:0] a, input logic [AW-1:0] lo,
                                  input logic [AW-1:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_uid(input logic [AW-1:0] a);
    is_uid = in_rng(a, UID_BASE, UID_LAST);
  endfunction

  function automatic logic is_cfgw(input logic [AW-1:0] a);
    is_cfgw = in_rng(a, CFGW_BASE, CFGW_LAST);
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    is_mapped = is_uid(a) || is_cfgw(a) || in_rng(a, INFO_BASE, INFO_LAST) ||
                in_rng(a, DCFG_BASE, DCFG_LAST) || in_rng(a, ID_BASE, ID_LAST);
  endfunction

  // control byte as the controller writes it; fault bit 1 leaves the fault alone
  function automatic logic [DW-1:0] ctl_byte(input logic [1:0] spc, input logic ers,
                                             input logic arm, input logic go);
    ctl_byte = {spc, 2'h0, 1'b1, ers, arm, go};
  endfunction
endpackage

/* rtl/cnv_store.sv */
// nonvolatile byte array plus the two bits that survive a system reset
// assumes por_n is only pulsed at power-up; the array itself is never reset
`timescale 1ns/1ns
`default_nettype none
module cnv_store import cnv_pkg::*; #(
  parameter int DEPTH = MEM_DEPTH
) (
  input wire logic clk,
  input wire logic por_n,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DW-1:0] rd_data,
  input wire logic we,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DW-1:0] wr_data,
  input wire logic hv_set,
  input wire logic hv_clr,
  input wire logic quirk_set,
  output logic hv_ret,
  output logic quirk_ret
);
  logic [DW-1:0] mem [DEPTH];
  logic hv_reg;
  logic quirk_reg;

  // asynchronous read, like a sense amplifier on the selected byte
  assign rd_data = mem[rd_idx];
  assign hv_ret = hv_reg;
  assign quirk_ret = quirk_reg;

  // byte write at the end of the high-voltage cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // retained bits: power-up clears both and hv_clr also clears hv_reg, so a system reset cannot hide them
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      hv_reg <= 1'b0;
      quirk_reg <= 1'b0;
    end else begin
      hv_reg <= hv_set | (hv_reg & ~hv_clr);
      quirk_reg <= quirk_reg | quirk_set; // never cleared until power cycles
    end
  end
endmodule
`default_nettype wire
